// >>> hw/trap_and_interrupt_vectoring.v
`timescale 1ns/1ps
`include "trap_vector_defines.vh"
module trap_and_interrupt_vectoring #(
    parameter NODES = 30
) (
    input wire ref_clk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Trap sources, one-cycle pulses from the core
    input wire nmiReq,
    input wire unknownOpcode,
    input wire protectedFault,
    input wire misalignedOperand,
    input wire badFetchTarget,
    input wire badExternalAccess,
    input wire softReset,
    input wire watchdogOverflow,
    input wire swTrapReq,
    input wire [6:0] swTrapNum,
    // Stack access from the core
    input wire stackAccess,
    input wire [15:0] stackPointer,
    // Peripheral node requests, one pulse per event
    input wire [NODES-1:0] nodeEvent,
    // Event transfer engine claims a node; the CPU branch is raised for it as well
    input wire [NODES-1:0] nodeToTransfer,
    // Core signals end of the current service (return)
    input wire serviceDone,
    // Branch request to the pipeline
    output reg branchValid,
    output reg [8:0] branchAddr,
    output reg [6:0] branchTrapNum,
    output reg transferValid,
    output reg [4:0] transferNode,
    output reg irq
);
    // Fixed trap numbers of the nodes, in table order
    function [6:0] nodeTrap;
        input integer i;
        begin
            case (i)
                0,1,2,3,4,5,6,7: nodeTrap = 7'h18 + i[6:0];
                8,9,10,11,12,13,14,15,16: nodeTrap = 7'h1a + i[6:0];
                17: nodeTrap = 7'h47;
                18,19,20,21,22: nodeTrap = 7'h19 + i[6:0];
                23,24,25,26,27,28,29: nodeTrap = 7'h29 + i[6:0];
                default: nodeTrap = 7'h7f;
            endcase
        end
    endfunction

    reg [7:0] cause_q;
    reg [15:0] stkUp_q;
    reg [15:0] stkLo_q;
    reg [7:0] irqSt_q;
    reg [7:0] irqMsk_q;
    reg [3:0] cpuPri_q;
    reg [1:0] trapPri_q;
    reg [5:0] nodeCtl_q [0:NODES-1];
    reg [3:0] savePri_q [0:3];
    reg [1:0] saveTp_q [0:3];
    reg [2:0] depth_q;

    wire apbWr = psel & penable & pwrite & pready;
    wire apbRd = psel & penable & ~pwrite & pready;
    wire [9:0] nodeIdx = paddr[11:2] - 10'h040;
    wire nodeHit = (paddr >= `REG_NODE0) &&
        (nodeIdx < NODES[9:0]);

    // Stack limit check on each stack access
    // limit compare
    wire stack_over_limit_flag = stackAccess && (stackPointer < stkUp_q);
    wire stack_under_limit_flag = stackAccess && (stackPointer > stkLo_q);
    wire classA = nmiReq | stack_over_limit_flag | stack_under_limit_flag;
    wire classB = unknownOpcode | protectedFault | misalignedOperand |
        badFetchTarget | badExternalAccess;
    wire [7:0] newCause = {badExternalAccess, badFetchTarget,
        misalignedOperand, protectedFault, unknownOpcode,
        stack_under_limit_flag, stack_over_limit_flag, nmiReq};
    wire anyReset = softReset | watchdogOverflow;

    // Pick the trap to take; class A first, then by table order
    reg takeTrap;
    reg [6:0] trapNum;
    reg [1:0] trapPri;
    always @* begin
        takeTrap = 1'b0;
        trapNum = `TN_NMI;
        trapPri = `TP_NONE;
        if (classA && trapPri_q < `TP_A) begin
            takeTrap = 1'b1;
            trapPri = `TP_A;
            if (nmiReq)
                trapNum = `TN_NMI;
            else if (stack_over_limit_flag)
                trapNum = `TN_OVER;
            else
                trapNum = `TN_UNDER;
        end else if (classB && trapPri_q < `TP_B) begin
            takeTrap = 1'b1;
            trapPri = `TP_B;
            trapNum = `TN_CLASSB;
        end
    end

    // Highest pending enabled node; lower index wins a tie
    reg nodeWin;
    reg [4:0] nodeSel;
    reg [3:0] nodePri;
    integer k;
    always @* begin
        nodeWin = 1'b0;
        nodeSel = 5'h00;
        nodePri = 4'h0;
        for (k = NODES - 1; k >= 0; k = k - 1) begin
            if (nodeCtl_q[k][`NC_IR] && nodeCtl_q[k][`NC_IE] &&
                nodeCtl_q[k][3:0] >= nodePri) begin
                nodeWin = 1'b1;
                nodeSel = k[4:0];
                nodePri = nodeCtl_q[k][3:0];
            end
        end
    end
    wire nodeTake = nodeWin && (nodePri > cpuPri_q) &&
        (trapPri_q == `TP_NONE) && !takeTrap && depth_q < 3'h4;
    wire svcEnd = serviceDone && depth_q != 3'h0;

    // Register file, stack limits and service nesting
    integer n;
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cause_q <= 8'h00;
            stkUp_q <= `RST_STKUP;
            stkLo_q <= `RST_STKLO;
            irqSt_q <= 8'h00;
            irqMsk_q <= 8'h00;
            cpuPri_q <= 4'h0;
            trapPri_q <= `TP_NONE;
            depth_q <= 3'h0;
            for (n = 0; n < NODES; n = n + 1)
                nodeCtl_q[n] <= 6'h00;
            for (n = 0; n < 4; n = n + 1) begin
                savePri_q[n] <= 4'h0;
                saveTp_q[n] <= `TP_NONE;
            end
        end else if (anyReset) begin
            cpuPri_q <= 4'h0;
            trapPri_q <= `TP_NONE;
            depth_q <= 3'h0;
        end else begin
            // Software writes a cause bit to one to clear it
            // cause bits, set wins
            cause_q <= (apbWr && paddr == `REG_CAUSE ?
                cause_q & ~pwdata[7:0] : cause_q) | newCause;
            // Sticky status, cleared by reading it; set wins
            irqSt_q <= (apbRd && paddr == `REG_IRQST ?
                8'h00 : irqSt_q) | newCause;
            if (apbWr && paddr == `REG_STKUP)
                stkUp_q <= pwdata[15:0];
            if (apbWr && paddr == `REG_STKLO)
                stkLo_q <= pwdata[15:0];
            if (apbWr && paddr == `REG_IRQMSK)
                irqMsk_q <= pwdata[7:0];
            // Node controls; hardware events set the request bit
            for (n = 0; n < NODES; n = n + 1) begin
                if (apbWr && nodeHit && nodeIdx == n)
                    nodeCtl_q[n] <= pwdata[5:0];
                if (nodeEvent[n])
                    nodeCtl_q[n][`NC_IR] <= 1'b1;
                else if (nodeTake && nodeSel == n)
                    nodeCtl_q[n][`NC_IR] <= 1'b0;
            end
            // Nesting: push on entry, pop on return
            if (takeTrap || nodeTake) begin
                savePri_q[depth_q[1:0]] <= cpuPri_q;
                saveTp_q[depth_q[1:0]] <= trapPri_q;
                depth_q <= depth_q + 3'h1;
                if (takeTrap) begin
                    // Trap service masks every node level
                    cpuPri_q <= 4'hf;
                    trapPri_q <= trapPri;
                end else
                    cpuPri_q <= nodePri;
            end else if (svcEnd) begin
                cpuPri_q <= savePri_q[depth_q[1:0] - 2'h1];
                trapPri_q <= saveTp_q[depth_q[1:0] - 2'h1];
                depth_q <= depth_q - 3'h1;
            end
        end
    end

    // Branch and transfer outputs; all registered
    always @(posedge ref_clk) begin
        if (!rstn) begin
            branchValid <= 1'b1;
            branchAddr <= 9'h000;
            branchTrapNum <= `TN_RESET;
            transferValid <= 1'b0;
            transferNode <= 5'h00;
            irq <= 1'b0;
        end else begin
            branchValid <= anyReset | takeTrap | nodeTake | swTrapReq;
            transferValid <= nodeTake && nodeToTransfer[nodeSel];
            transferNode <= nodeSel;
            irq <= |(irqSt_q & irqMsk_q);
            if (anyReset) begin
                branchTrapNum <= `TN_RESET;
                branchAddr <= 9'h000;
            end else if (takeTrap) begin
                branchTrapNum <= trapNum;
                branchAddr <= {trapNum, 2'b00};
            end else if (nodeTake) begin
                branchTrapNum <= nodeTrap(nodeSel);
                branchAddr <= {nodeTrap(nodeSel), 2'b00};
            end else if (swTrapReq) begin
                branchTrapNum <= swTrapNum;
                branchAddr <= {swTrapNum, 2'b00};
            end
        end
    end

    // APB: one wait state, unmapped reads zero with error
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel & penable & ~pready) begin
                if (nodeHit)
                    prdata <= {26'h0, nodeCtl_q[nodeIdx[4:0]]};
                else
                    case (paddr)
                        `REG_CAUSE: prdata <= {24'h0, cause_q};
                        `REG_STKUP: prdata <= {16'h0, stkUp_q};
                        `REG_STKLO: prdata <= {16'h0, stkLo_q};
                        `REG_IRQST: prdata <= {24'h0, irqSt_q};
                        `REG_IRQMSK: prdata <= {24'h0, irqMsk_q};
                        `REG_CPUPRI: prdata <= {28'h0, cpuPri_q};
                        `REG_SVC: prdata <= {27'h0, trapPri_q, depth_q};
                        default: pslverr <= 1'b1;
                    endcase
            end
        end
    end
endmodule

// >>> hw/trap_vector_defines.vh
// Function
// - Hardware traps are non-maskable; taken regardless of enables, unless a trap service of equal or higher class is open.
// - A taken class A trap branches to its own fixed vector entry; class B traps share one.
// - Each class A and class B trap sets its own cause bit in the trap cause register.
// - A trap preempts anything except a trap service of equal or higher priority in progress.
// - Trap services block standard interrupts and event transfer requests.
// - Class A: NMI 0x08/02, stack over 0x10/04, stack under 0x18/06.
// - Five class B causes share vector 0x28, each with its own flag.
// - Each node has request, enable, fixed vector; first node 0x60, trap 0x18.
// - Each node control register holds a four-bit priority field.
// - An accepted service is only interrupted by strictly higher priority; here a swTrapReq branches regardless of any open service.
// - Stack pointer is checked against both limits on every stack access.
`ifndef TRAP_VECTOR_DEFINES_VH
`define TRAP_VECTOR_DEFINES_VH
// Register byte addresses
`define REG_CAUSE 12'h000
`define REG_STKUP 12'h004
`define REG_STKLO 12'h008
`define REG_IRQST 12'h00c
`define REG_IRQMSK 12'h010
`define REG_CPUPRI 12'h014
`define REG_SVC 12'h018
`define REG_NODE0 12'h100
// Cause register bit positions
`define CB_NMI 0
`define CB_OVER 1
`define CB_UNDER 2
`define CB_OPCODE 3
`define CB_PROT 4
`define CB_OPA 5
`define CB_INA 6
`define CB_BUS 7
// Node control fields
`define NC_PRI_LSB 0
`define NC_IE 4
`define NC_IR 5
// Trap numbers
`define TN_RESET 7'h00
`define TN_NMI 7'h02
`define TN_OVER 7'h04
`define TN_UNDER 7'h06
`define TN_CLASSB 7'h0a
// Trap priorities (class A above class B)
`define TP_A 2'h3
`define TP_B 2'h2
`define TP_NONE 2'h0
// Reset values
`define RST_STKUP 16'hfa00
`define RST_STKLO 16'hfc00
`endif

// >>> test/trap_vector_checker.sv
`timescale 1ns/1ps
`include "trap_vector_defines.vh"
module trap_vector_checker (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire nmiReq,
    input wire unknownOpcode,
    input wire protectedFault,
    input wire misalignedOperand,
    input wire badFetchTarget,
    input wire badExternalAccess,
    input wire softReset,
    input wire watchdogOverflow,
    input wire stackAccess,
    input wire [15:0] stackPointer,
    input wire serviceDone,
    input wire branchValid,
    input wire [8:0] branchAddr,
    input wire [6:0] branchTrapNum
);
    logic [3:0] depth_q;
    logic idle;
    logic classB;
    // Entry checks only hold with no service open: refusal is legal only while one is open
    assign idle = depth_q == 4'h0;
    assign classB = unknownOpcode | protectedFault | misalignedOperand
        | badFetchTarget | badExternalAccess;
    // Open services: entries minus returns, a restart empties them
    always_ff @(posedge ref_clk) begin
        if (!rstn || (branchValid && branchTrapNum == 7'h00)) begin
            depth_q <= 4'h0;
        end else begin
            depth_q <= depth_q + {3'h0, branchValid} - {3'h0, serviceDone};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbAccess;
        psel && penable;
    endsequence
    chk_apb_answer: assert property (apbSetup ##1 apbAccess |=> pready)
        else $error("ready missing after access start");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    chk_addr_times4: assert property (
        branchValid |-> branchAddr == {branchTrapNum, 2'b00})
        else $error("vector is not trap number times four");
    chk_nmi_entry: assert property (
        nmiReq && idle |=> branchValid && branchTrapNum == `TN_NMI)
        else $error("nmi not vectored");
    chk_over_entry: assert property (
        stackAccess && idle && stackPointer < `RST_STKUP
        |=> branchValid && branchTrapNum == `TN_OVER)
        else $error("stack overflow not vectored");
    chk_under_entry: assert property (
        stackAccess && idle && stackPointer > `RST_STKLO
        |=> branchValid && branchTrapNum == `TN_UNDER)
        else $error("stack underflow not vectored");
    chk_classb_shared: assert property (
        classB && idle |=> branchValid && branchTrapNum == `TN_CLASSB)
        else $error("class b cause not on shared vector");
    chk_restart_zero: assert property (
        softReset || watchdogOverflow |=> branchValid && branchAddr == 9'h000)
        else $error("restart not at vector zero");
endmodule
bind trap_and_interrupt_vectoring trap_vector_checker chk (.*);

// >>> test/core_model.sv
`timescale 1ns/1ps
// Core stand-in: returns from each entered service after a short run
module core_model #(
    parameter int DELAY = 3
) (
    input wire ref_clk,
    input wire rstn,
    input wire branchValid,
    input wire [6:0] branchTrapNum,
    input wire hold,
    output logic serviceDone
);
    logic [2:0] pend_q;
    logic [3:0] wait_q;
    logic doneNow;
    // Holding returns back lets a test stack services on purpose
    assign doneNow = pend_q != 3'h0 && !hold && wait_q == 4'(DELAY);
    // Count open services and pace the returns
    always_ff @(posedge ref_clk) begin
        if (!rstn || (branchValid && branchTrapNum == 7'h00)) begin
            pend_q <= 3'h0;
            wait_q <= 4'h0;
            serviceDone <= 1'b0;
        end else begin
            serviceDone <= doneNow;
            wait_q <= (doneNow || pend_q == 3'h0) ? 4'h0 :
                (wait_q == 4'(DELAY) ? wait_q : wait_q + 4'h1);
            pend_q <= pend_q + {2'h0, branchValid} - {2'h0, doneNow};
        end
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("ERROR %0t got %h want %h", $time, (a), (b)); \
    end \
end
module tb;
    logic ref_clk = 0;
    logic rstn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic hold = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [9:0] src = 0;
    logic [6:0] swTrapNum = 0;
    logic [15:0] stackPointer = 16'hfb00;
    logic [29:0] nodeEvent = 0;
    logic [29:0] xfer = 0;
    wire transferValid;
    wire [4:0] transferNode;
    wire [31:0] prdata;
    wire pready, pslverr, branchValid, irq, serviceDone;
    wire [8:0] branchAddr;
    wire [6:0] branchTrapNum;
    int error_cnt = 0;
    int tests_run = 0;
    logic [31:0] r;
    logic e;
    logic [4:0] ix [4] = '{5'd0, 5'd8, 5'd17, 5'd29};
    logic [6:0] tn [4] = '{7'h18, 7'h22, 7'h47, 7'h46};
    // Free-running core clock
    always #2 ref_clk = ~ref_clk;
    trap_and_interrupt_vectoring #(.NODES(30)) dut (.*,
        .nmiReq(src[0]), .unknownOpcode(src[1]), .protectedFault(src[2]),
        .misalignedOperand(src[3]), .badFetchTarget(src[4]),
        .badExternalAccess(src[5]), .softReset(src[6]),
        .watchdogOverflow(src[7]), .swTrapReq(src[8]), .stackAccess(src[9]),
        .nodeToTransfer(xfer), .transferValid(transferValid),
        .transferNode(transferNode));
    core_model cpu (.*);
    // One APB transfer; read data and error land in r and e
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Gap first so the previous service has returned
    task pulse(input int b);
        repeat (6) @(posedge ref_clk);
        src[b] <= 1;
        @(posedge ref_clk);
        src[b] <= 0;
    endtask
    task wbr(input logic [6:0] t);
        int n;
        n = 0;
        do @(posedge ref_clk); while (branchValid !== 1'b1 && ++n < 20);
        `CHK(branchValid, 1'b1)
        `CHK(branchTrapNum, t)
        `CHK(branchAddr, {t, 2'b00})
    endtask
    task nobr;
        repeat (10) begin
            @(posedge ref_clk);
            `CHK(branchValid, 1'b0)
        end
    endtask
    task t_classes;
        apb(0, 12'h004, 0);
        `CHK(r[15:0], `RST_STKUP)
        apb(1, 12'h000, 32'hff);
        pulse(0); wbr(7'h02);
        stackPointer <= 16'hf900;
        pulse(9); wbr(7'h04);
        stackPointer <= 16'hfd00;
        pulse(9); wbr(7'h06);
        stackPointer <= 16'hfb00;
        pulse(9); nobr;
        apb(0, 12'h000, 0);
        `CHK(r[7:0], 8'h07)
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h000, 32'hff);
            pulse(1 + i); wbr(7'h0a);
            apb(0, 12'h000, 0);
            `CHK(r[7:0], 8'h08 << i)
        end
    endtask
    task t_nodes;
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h100 | {5'h0, ix[i], 2'b00}, 32'h3f);
            wbr(tn[i]);
        end
        apb(1, 12'h104, 32'h13);
        xfer[1] <= 1;
        nodeEvent[1] <= 1;
        @(posedge ref_clk);
        nodeEvent[1] <= 0;
        wbr(7'h19);
        `CHK(transferValid, 1'b1)
        `CHK(transferNode, 5'd1)
        xfer[1] <= 0;
        apb(1, 12'h108, 32'h2f); nobr;
        apb(1, 12'h108, 32'h00);
    endtask
    // Node under way, an equal node request, then a trap on top, then a lower trap request
    task t_preempt;
        hold <= 1;
        apb(1, 12'h100, 32'h3f); wbr(7'h18);
        apb(1, 12'h104, 32'h3f); nobr;
        pulse(0); wbr(7'h02);
        nobr;
        pulse(1); nobr;
        apb(0, 12'h000, 0);
        `CHK(r[3], 1'b1)
        hold <= 0;
        wbr(7'h19);
    endtask
    task t_irq;
        apb(1, 12'h010, 32'h1);
        pulse(0); wbr(7'h02);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        apb(0, 12'h00c, 0);
        `CHK(r[0], 1'b1)
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        apb(1, 12'h010, 32'h0);
        pulse(0); wbr(7'h02);
        repeat (3) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        apb(0, 12'h00c, 0);
    endtask
    task t_misc;
        apb(0, 12'h040, 0);
        `CHK({e, r}, 33'h100000000)
        swTrapNum <= 7'h7f;
        pulse(8); wbr(7'h7f);
        apb(1, 12'h000, 32'hff);
        pulse(6); wbr(7'h00);
        pulse(7); wbr(7'h00);
        apb(0, 12'h000, 0);
        `CHK(r[7:0], 8'h00)
    endtask
    task test_done;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        `CHK(branchValid, 1'b1)
        rstn <= 1;
        t_classes;
        t_nodes;
        t_preempt;
        t_irq;
        t_misc;
        test_done;
    end
    // Hang guard
    initial begin
        #40000;
        error_cnt++;
        test_done;
    end
endmodule
